/* src/dpc_pkg.sv */
// constants and types for the debounced four-bit port
// Notes on behaviour
// - reset makes all four bits inputs; each bit's direction is then set alone.
// - port write loads the output latches; only output bits drive their pins.
// - port read returns the levels on input-mode pins.
// - port read returns the latch value for output-mode bits.
// - with the pull-down option, pull-downs exist and the mode write switches them.
// - pull-down and hold never both on; operand 10h pull-down, 0h hold.
// - with the hold option, reset enables pull-down and disables hold.
// - output bits have pull-down and hold both off.
// - debounce clock selects 32ms, 8ms or 2ms tap; reset selects 32ms.
// - output pins never feed the debounce circuit.
// - a change counts only on one pin while the other pins are low.
// - selected pins set the start flag after two stable debounce periods.
// - a set start flag stops the debounce clock until cleared.
// - the wake-select write clears the start flag and restarts the clock.
// - start flag raises halt-release request; interrupt if enabled.
// - a pin given a non-port function has no port input or output.
package dpc_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_OUT    = 8'h04;
  localparam logic [7:0] OFS_IN     = 8'h08;
  localparam logic [7:0] OFS_CLKSEL = 8'h0C;
  localparam logic [7:0] OFS_WAKE   = 8'h10;
  localparam logic [7:0] OFS_FLAG   = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_MASK   = 8'h1C;

  // mode operand fields
  localparam int MODE_DIR_LSB = 0;
  localparam int MODE_PULL_BIT = 4;

  // debounce tap selections
  localparam logic [1:0] TAP_32MS = 2'h0;
  localparam logic [1:0] TAP_8MS  = 2'h1;
  localparam logic [1:0] TAP_2MS  = 2'h2;

  // reset values
  localparam logic [3:0] RST_DIR     = 4'h0;
  localparam logic       RST_PULL    = 1'h1;
  localparam logic [3:0] RST_LATCH   = 4'h0;
  localparam logic [1:0] RST_TAP     = TAP_32MS;
  localparam logic [3:0] RST_WAKE    = 4'h0;
  localparam logic       RST_IRQ_EN  = 1'h0;

  // stable debounce periods before an event
  localparam logic [1:0] DEB_PERIODS = 2'h2;

  // pad controls
  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] oe;
    logic [3:0] pull_dn;
    logic [3:0] hold;
  } dpc_pad_t;

endpackage : dpc_pkg

/* src/dpc_sync3.sv */
// three-stage synchroniser with agreement filter
`timescale 1ns/100ps
module dpc_sync3 (
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic arst_n_in,
  // data
  input  wire logic d_in,
  output logic      q_out
);

  logic ff1;
  logic ff2;
  logic ff3;

  // plain chain
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ff1 <= 1'b0;
      ff2 <= 1'b0;
      ff3 <= 1'b0;
    end
    else
    begin
      ff1 <= d_in;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // accept once second and third agree
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      q_out <= 1'b0;
    else if (ff2 == ff3)
      q_out <= ff3;
  end

endmodule : dpc_sync3

/* src/dpc_port_c.sv */
// four-bit port with debounce, wake flag and apb registers
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module dpc_port_c
  import dpc_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        arst_n_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic [31:0]      prdata_out,
  // build options
  input  wire logic        pulldown_opt_in,
  input  wire logic        hold_opt_in,
  input  wire logic [3:0]  alt_fn_in,
  // divider taps
  input  wire logic        divider_tap_32ms_in,
  input  wire logic        divider_tap_8ms_in,
  input  wire logic        divider_tap_2ms_in,
  // pins
  input  wire logic [3:0]  port_c_in,
  output dpc_pad_t         pad_out,
  // events
  output logic             port_change_start_flag_out,
  output logic             halt_release_req_port_out,
  output logic             irq_out
);

  logic [3:0]  dir;
  logic        pull_sel;
  logic [3:0]  out_latch;
  logic [1:0]  tap_sel;
  logic [3:0]  wake_sel;
  logic        start_flag;
  logic        hrf_sts;
  logic        irq_en;
  logic [3:0]  pin_s;
  logic [2:0]  tap_raw;
  logic [2:0]  tap_s;
  logic [2:0]  tap_d;
  logic        tick;
  logic [3:0]  live;
  logic [3:0]  samp;
  logic [3:0]  cand;
  logic [3:0]  prev;
  logic [1:0]  cnt;
  logic [3:0]  chg;
  logic        one_hot;
  logic        change_ev;
  logic [3:0]  port_rd;
  logic        acc;
  logic        wr_go;
  logic        hit;
  logic [31:0] next_prdata;
  dpc_pad_t    next_pad;

  // pin synchronisers
  for (genvar i = 0; i < 4; i++)
  begin : g_pin
    dpc_sync3 u_sync (
      .sys_clk_in (sys_clk_in),
      .arst_n_in  (arst_n_in),
      .d_in       (port_c_in[i]),
      .q_out      (pin_s[i])
    );
  end

  assign tap_raw = {divider_tap_2ms_in,
                    divider_tap_8ms_in,
                    divider_tap_32ms_in};

  // tap synchronisers
  for (genvar t = 0; t < 3; t++)
  begin : g_tap
    dpc_sync3 u_sync (
      .sys_clk_in (sys_clk_in),
      .arst_n_in  (arst_n_in),
      .d_in       (tap_raw[t]),
      .q_out      (tap_s[t])
    );
  end

  // apb phase decode
  assign acc   = psel_in & penable_in;
  assign wr_go = acc & pready_out & pwrite_in;

  always_comb
  begin
    hit = 1'b1;
    case (paddr_in)
      OFS_MODE, OFS_OUT, OFS_IN, OFS_CLKSEL,
      OFS_WAKE, OFS_FLAG, OFS_STATUS, OFS_MASK:
        hit = 1'b1;
      default:
        hit = 1'b0;
    endcase
  end

  // one wait state, then ready
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      pready_out <= 1'b0;
    else
      pready_out <= acc & ~pready_out;
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      pslverr_out <= 1'b0;
    else if (acc & ~pready_out)
      pslverr_out <= ~hit;
    else
      pslverr_out <= 1'b0;
  end

  // port readback
  always_comb
  begin
    port_rd = ((dir & out_latch) | (~dir & pin_s));
    port_rd = port_rd & ~alt_fn_in;
  end

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    case (paddr_in)
      OFS_MODE:
        next_prdata[4:0] = {pull_sel, dir};
      OFS_OUT:
        next_prdata[3:0] = out_latch;
      OFS_IN:
        next_prdata[3:0] = port_rd;
      OFS_CLKSEL:
        next_prdata[1:0] = tap_sel;
      OFS_WAKE:
        next_prdata[3:0] = wake_sel;
      OFS_FLAG:
        next_prdata[0] = start_flag;
      OFS_STATUS:
        next_prdata[0] = hrf_sts;
      OFS_MASK:
        next_prdata[0] = irq_en;
      default:
        next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      prdata_out <= 32'h0000_0000;
    else if (acc & ~pready_out & ~pwrite_in)
      prdata_out <= next_prdata;
  end

  // direction and pull select
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      dir      <= RST_DIR;
      pull_sel <= RST_PULL;
    end
    else if (wr_go && paddr_in == OFS_MODE)
    begin
      dir      <= pwdata_in[MODE_DIR_LSB +: 4];
      pull_sel <= pwdata_in[MODE_PULL_BIT];
    end
  end

  // output latches
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      out_latch <= RST_LATCH;
    else if (wr_go && paddr_in == OFS_OUT)
      out_latch <= pwdata_in[3:0];
  end

  // debounce tap select
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      tap_sel <= RST_TAP;
    else if (wr_go && paddr_in == OFS_CLKSEL)
    begin
      case (pwdata_in[1:0])
        TAP_32MS, TAP_8MS, TAP_2MS:
          tap_sel <= pwdata_in[1:0];
        default:
          tap_sel <= tap_sel;
      endcase
    end
  end

  // wake select
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      wake_sel <= RST_WAKE;
    else if (wr_go && paddr_in == OFS_WAKE)
      wake_sel <= pwdata_in[3:0];
  end

  // interrupt enable
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      irq_en <= RST_IRQ_EN;
    else if (wr_go && paddr_in == OFS_MASK)
      irq_en <= pwdata_in[0];
  end

  // pad drive
  always_comb
  begin
    next_pad.dout    = out_latch;
    next_pad.oe      = dir & ~alt_fn_in;
    next_pad.pull_dn = {4{pulldown_opt_in & pull_sel}}
                       & ~dir & ~alt_fn_in;
    next_pad.hold    = {4{hold_opt_in & ~pull_sel}}
                       & ~dir & ~alt_fn_in;
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      pad_out <= '0;
    else
      pad_out <= next_pad;
  end

  // tap edge, stopped while flag set
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      tap_d <= 3'h0;
    else
      tap_d <= tap_s;
  end

  always_comb
  begin
    case (tap_sel)
      TAP_8MS:
        tick = tap_s[1] & ~tap_d[1];
      TAP_2MS:
        tick = tap_s[2] & ~tap_d[2];
      default:
        tick = tap_s[0] & ~tap_d[0];
    endcase
    tick = tick & ~start_flag;
  end

  // debounce sampling
  assign live = ~dir & ~alt_fn_in & wake_sel;
  assign samp = pin_s & live;
  assign chg  = cand ^ prev;

  always_comb
  begin
    case (chg)
      4'h1, 4'h2, 4'h4, 4'h8:
        one_hot = 1'b1;
      default:
        one_hot = 1'b0;
    endcase
  end

  // single pin changing, others low
  assign change_ev = tick & (samp == cand) & (cnt == DEB_PERIODS - 2'h1)
                     & one_hot & ((cand & ~chg) == 4'h0);

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cand <= 4'h0;
      cnt  <= 2'h0;
    end
    else if (tick)
    begin
      if (samp != cand)
      begin
        cand <= samp;
        cnt  <= 2'h0;
      end
      else if (cand == prev || change_ev)
        cnt <= 2'h0;
      else if (cnt < DEB_PERIODS)
        cnt <= cnt + 2'h1;
    end
  end

  // accepted level
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      prev <= 4'h0;
    else if (tick && (samp == cand) && (cnt != 2'h0 || cand == prev))
      prev <= cand;
  end

  // start flag, set beats clear
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      start_flag <= 1'b0;
    else if (change_ev)
      start_flag <= 1'b1;
    else if (wr_go && paddr_in == OFS_WAKE)
      start_flag <= 1'b0;
  end

  // sticky halt-release status, write one to clear
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      hrf_sts <= 1'b0;
    else if (change_ev)
      hrf_sts <= 1'b1;
    else if (wr_go && paddr_in == OFS_STATUS && pwdata_in[0])
      hrf_sts <= 1'b0;
  end

  // event outputs
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      port_change_start_flag_out <= 1'b0;
      halt_release_req_port_out  <= 1'b0;
      irq_out                    <= 1'b0;
    end
    else
    begin
      port_change_start_flag_out <= start_flag;
      halt_release_req_port_out  <= hrf_sts;
      irq_out                    <= hrf_sts & irq_en;
    end
  end

endmodule : dpc_port_c

/* testbench/dpc_switch_model.sv */
// switches on the four port pins, with pad drive resolved
`timescale 1ns/100ps
module dpc_switch_model
  import dpc_pkg::*;
(
  // switch levels
  input  wire logic [3:0] sw_in,
  // pad controls
  input  wire dpc_pad_t   pad_in,
  // resolved pins
  output logic [3:0]      pins_out
);
  // a driving pad overrides the switch
  assign pins_out = (pad_in.oe & pad_in.dout) | (~pad_in.oe & sw_in);
endmodule : dpc_switch_model

/* testbench/dpc_port_c_monitor.sv */
// assertions on the debounced port outputs
`timescale 1ns/100ps
module dpc_port_c_monitor
  import dpc_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk_in,
  input wire logic        arst_n_in,
  // apb
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        pready_out,
  // pins and events
  input wire logic [3:0]  alt_fn_in,
  input wire dpc_pad_t    pad_out,
  input wire logic        port_change_start_flag_out,
  input wire logic        halt_release_req_port_out,
  input wire logic        irq_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  logic acc;
  logic mw;
  logic ow;
  logic wk;
  assign acc = psel_in & penable_in & pready_out & pwrite_in;
  assign mw = acc & (paddr_in == OFS_MODE);
  assign ow = acc & (paddr_in == OFS_OUT);
  assign wk = acc & (paddr_in == OFS_WAKE);
  property p_dir;
    mw |-> ##2 pad_out.oe == ($past(pwdata_in[3:0], 2) & ~alt_fn_in);
  endproperty
  a_dir: assert property (p_dir) else $error("bad oe");
  property p_out;
    ow |-> ##2 (pad_out.dout & pad_out.oe) ==
      ($past(pwdata_in[3:0], 2) & pad_out.oe);
  endproperty
  a_out: assert property (p_out) else $error("bad dout");
  property p_oe_pull;
    ~|(pad_out.oe & (pad_out.pull_dn | pad_out.hold));
  endproperty
  a_oe_pull: assert property (p_oe_pull) else $error("pull on");
  property p_excl;
    ~|(pad_out.pull_dn & pad_out.hold);
  endproperty
  a_excl: assert property (p_excl) else $error("pull and hold");
  property p_hrf;
    $rose(port_change_start_flag_out) |-> halt_release_req_port_out;
  endproperty
  a_hrf: assert property (p_hrf) else $error("no request");
  property p_irq;
    irq_out |-> halt_release_req_port_out;
  endproperty
  a_irq: assert property (p_irq) else $error("stray irq");
  property p_clr;
    wk && port_change_start_flag_out |-> ##2 !port_change_start_flag_out;
  endproperty
  a_clr: assert property (p_clr) else $error("flag kept");
  property p_hold_flag;
    port_change_start_flag_out && !wk && !$past(wk)
      |=> port_change_start_flag_out;
  endproperty
  a_hold_flag: assert property (p_hold_flag) else $error("flag lost");
  c_flag: cover property ($rose(port_change_start_flag_out));
  c_irq: cover property ($rose(irq_out));
  c_mode: cover property (mw);
endmodule : dpc_port_c_monitor

bind dpc_port_c dpc_port_c_monitor mon_u (
  .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .pready_out(pready_out), .alt_fn_in(alt_fn_in),
  .pad_out(pad_out),
  .port_change_start_flag_out(port_change_start_flag_out),
  .halt_release_req_port_out(halt_release_req_port_out),
  .irq_out(irq_out)
);

/* testbench/tb.sv */
// self-checking bench for the debounced port
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  err_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb
  import dpc_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [2:0]  tap = 3'h0;
  logic [3:0]  sw = 4'h0;
  logic        msk = 1'b0;
  logic        popt = 1'b1;
  logic        hopt = 1'b1;
  logic        rdy, serr, flag, hrf, irq;
  logic [31:0] prdata;
  logic [3:0]  pins;
  dpc_pad_t    pad;
  int          err_count = 0;
  int          comparisons = 0;

  always #25 clk = ~clk;

  dpc_port_c dut_u (
    .sys_clk_in(clk), .arst_n_in(rst_n), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .pready_out(rdy), .pslverr_out(serr),
    .prdata_out(prdata), .pulldown_opt_in(popt), .hold_opt_in(hopt),
    .alt_fn_in(4'h8), .divider_tap_32ms_in(tap[0]),
    .divider_tap_8ms_in(tap[1]), .divider_tap_2ms_in(tap[2]),
    .port_c_in(pins), .pad_out(pad), .port_change_start_flag_out(flag),
    .halt_release_req_port_out(hrf), .irq_out(irq)
  );
  dpc_switch_model sw_u (.sw_in(sw), .pad_in(pad), .pins_out(pins));

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [32:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    r = {serr, prdata};
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(a, 1'b1, d, r);
    repeat (2) @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    logic [32:0] r;
    apb(a, 1'b0, 32'h0000_0000, r);
    `CHK("read", x, r)
  endtask : rd

  task automatic pulse(input int k, input int n);
    repeat (n)
    begin
      tap[k] <= 1'b1;
      repeat (8) @(posedge clk);
      tap[k] <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask : pulse

  task automatic deb(input logic [3:0] s, input int k, input logic x);
    wr(OFS_CLKSEL, 32'(k));
    sw <= s;
    repeat (8) @(posedge clk);
    for (int j = 0; j < 3; j++) if (j != k) pulse(j, 3);
    pulse(k, 2);
    `CHK("early", 1'b0, flag)
    pulse(k, 1);
    `CHK("flag", x, flag)
    `CHK("hrf", x, hrf)
    `CHK("irq", x & msk, irq)
    rd(OFS_FLAG, 33'(x));
    rd(OFS_IN, 33'(s & 4'h7));
    wr(OFS_STATUS, 32'h0000_0001);
    `CHK("hrf_clr", 1'b0, hrf)
    wr(OFS_WAKE, 32'h0000_0007);
    `CHK("flag_clr", 1'b0, flag)
    $display("debounce step done");
  endtask : deb

  task automatic results();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_MODE, 33'h0_0000_0010);
    rd(OFS_CLKSEL, 33'h0_0000_0000);
    wr(OFS_CLKSEL, 32'h0000_0003);
    rd(OFS_CLKSEL, 33'h0_0000_0000);
    `CHK("oe", 4'h0, pad.oe)
    `CHK("pull", 4'h7, pad.pull_dn)
    `CHK("hold", 4'h0, pad.hold)
    $display("reset test done");
    wr(OFS_MODE, 32'h0000_0000);
    `CHK("hold", 4'h7, pad.hold)
    `CHK("pull", 4'h0, pad.pull_dn)
    $display("pull select test done");
    wr(OFS_OUT, 32'h0000_000A);
    wr(OFS_MODE, 32'h0000_001B);
    sw <= 4'hC;
    repeat (8) @(posedge clk);
    rd(OFS_IN, 33'h0_0000_0006);
    `CHK("oe", 4'h3, pad.oe)
    `CHK("dout", 4'h2, pad.dout & pad.oe)
    `CHK("pull", 4'h4, pad.pull_dn)
    `CHK("hold", 4'h0, pad.hold)
    rd(8'h20, 33'h1_0000_0000);
    $display("port io test done");
    wr(OFS_MODE, 32'h0000_0010);
    wr(OFS_WAKE, 32'h0000_0007);
    wr(OFS_MASK, 32'h0000_0001);
    msk = 1'b1;
    rd(OFS_MASK, 33'h0_0000_0001);
    deb(4'h1, 0, 1'b1);
    deb(4'h0, 1, 1'b1);
    deb(4'h1, 2, 1'b1);
    wr(OFS_MASK, 32'h0000_0000);
    msk = 1'b0;
    wr(OFS_MODE, 32'h0000_0012);
    deb(4'h2, 0, 1'b1);
    wr(OFS_MODE, 32'h0000_0010);
    deb(4'h3, 0, 1'b0);
    popt <= 1'b0;
    hopt <= 1'b0;
    wr(OFS_MODE, 32'h0000_0010);
    `CHK("pull_off", 4'h0, pad.pull_dn)
    wr(OFS_MODE, 32'h0000_0000);
    `CHK("hold_off", 4'h0, pad.hold)
    $display("build option test done");
    results();
  end

  initial
  begin
    #2_000_000;
    err_count++;
    results();
  end
endmodule : tb
